// ### hw/liu_consts.svh
// offsets, field positions, reset values for the channel change latch block
`ifndef LIU_CONSTS_SVH
`define LIU_CONSTS_SVH

`define LIU_OFS_ENABLE 12'hf04
`define LIU_OFS_STATUS 12'hf05
`define LIU_OFS_LATCH 12'hf06

`define LIU_BIT_RSVD 7
`define LIU_BIT_DRIVE_MON 6
`define LIU_BIT_FIFO_LIM 5
`define LIU_BIT_CODE_VIOL 4
`define LIU_BIT_LOOP_CODE 3
`define LIU_FIELD_HI 6
`define LIU_FIELD_LO 3
`define LIU_COND_W 4

`define LIU_LATCH_RESET 4'h0
`define LIU_ENABLE_RESET 4'h0
`define LIU_BYTE_RESET 8'h00
`define LIU_LOW_ZERO 3'h0
// write-to-clear lanes, order [6:3]; code violation latch clears on read only
`define LIU_WC_MASK 4'hd
`define LIU_SYNC_RESET 4'h0

`endif

// ### hw/liu_types_pkg.sv
// types shared by the channel change latch block
package liu_types_pkg;
	typedef logic [3:0] cond_type;
	typedef logic [11:0] addr_type;
	typedef logic [7:0] byte_type;
endpackage

// ### hw/cond_sync.sv
// two-flop synchroniser with change detection for the live condition levels
`timescale 1ns/100ps
`default_nettype none
`include "liu_consts.svh"

module cond_sync (
	// clock, reset, enable
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// raw levels
	input wire liu_types_pkg::cond_type level_in,
	// synchronised level and change
	output liu_types_pkg::cond_type level_r,
	output liu_types_pkg::cond_type change
);
	import liu_types_pkg::*;

	cond_type meta_r;
	cond_type meta_nxt;
	cond_type sync_r;
	cond_type sync_nxt;
	cond_type level_nxt;

	always_comb begin
		meta_nxt = meta_r;
		sync_nxt = sync_r;
		level_nxt = level_r;
		if (ce) begin
			meta_nxt = level_in;
			sync_nxt = meta_r;
			level_nxt = sync_r;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			meta_r <= `LIU_SYNC_RESET;
			sync_r <= `LIU_SYNC_RESET;
			level_r <= `LIU_SYNC_RESET;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
			level_r <= level_nxt;
		end
	end

	// any transition, either direction
	genvar i;
	generate
		for (i = 0; i < `LIU_COND_W; i++) begin : g_chg
			assign change[i] = ce & (sync_r[i] ^ level_r[i]);
		end
	endgenerate
endmodule
`default_nettype wire

// ### hw/liu_channel_irq_status_latch.sv
// channel change latches, live status, enable and interrupt output
// Contract
// - drive-monitor change latch, bit 6, sets when drive-monitor level changes
// - drive-monitor, fifo-limit, loop-code latches clear on read or by write
// - fifo-limit change latch, bit 5, sets when fifo-limit level changes
// - code-violation latch, bit 4, sets on level change, clears on read
// - loop-code change latch, bit 3, sets when loop-code detect level changes
// - live level of each condition readable at same bit in status register
// - bit 7 reserved reads zero; all latches zero after reset
// - enabled loop-code interrupt fires on every transition, either direction
`timescale 1ns/100ps
`default_nettype none
`include "liu_consts.svh"

module liu_channel_irq_status_latch (
	// clock, reset, enable
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// live condition levels, order [6:3]
	input wire logic drive_monitor_level,
	input wire logic fifo_limit_level,
	input wire logic code_violation_level,
	input wire logic loop_code_detect_level,
	// register port
	input wire liu_types_pkg::addr_type reg_addr,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire liu_types_pkg::byte_type reg_wdata,
	output liu_types_pkg::byte_type reg_rdata_r,
	// interrupt
	output logic irq_r
);
	import liu_types_pkg::*;

	function automatic logic hit(input addr_type a, input addr_type ofs);
		hit = (a == ofs);
	endfunction

	cond_type level_r;
	cond_type change;
	cond_type latch_r;
	cond_type latch_nxt;
	cond_type enable_r;
	cond_type enable_nxt;
	cond_type clr;
	byte_type rdata_nxt;
	logic irq_nxt;
	logic rd_latch;
	logic rd_status;
	logic rd_enable;
	logic wr_latch;
	logic wr_enable;

	cond_sync u_sync (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.level_in({drive_monitor_level, fifo_limit_level, code_violation_level,
			loop_code_detect_level}),
		.level_r(level_r),
		.change(change)
	);

	assign rd_latch = reg_rd & hit(reg_addr, `LIU_OFS_LATCH);
	assign rd_status = reg_rd & hit(reg_addr, `LIU_OFS_STATUS);
	assign rd_enable = reg_rd & hit(reg_addr, `LIU_OFS_ENABLE);
	assign wr_latch = reg_wr & hit(reg_addr, `LIU_OFS_LATCH);
	assign wr_enable = reg_wr & hit(reg_addr, `LIU_OFS_ENABLE);

	always_comb begin
		clr = `LIU_LATCH_RESET;
		latch_nxt = latch_r;
		enable_nxt = enable_r;
		rdata_nxt = reg_rdata_r;
		irq_nxt = irq_r;
		if (ce) begin
			// clear on read, or write-one-to-clear on the wc lanes
			if (rd_latch)
				clr = ~`LIU_LATCH_RESET;
			else if (wr_latch)
				clr = reg_wdata[`LIU_FIELD_HI:`LIU_FIELD_LO] & `LIU_WC_MASK;
			// a change in the clearing cycle survives
			latch_nxt = (latch_r & ~clr) | change;
			if (wr_enable)
				enable_nxt = reg_wdata[`LIU_FIELD_HI:`LIU_FIELD_LO];
			rdata_nxt = `LIU_BYTE_RESET;
			if (rd_latch)
				rdata_nxt = {1'b0, latch_r, `LIU_LOW_ZERO};
			else if (rd_status)
				rdata_nxt = {1'b0, level_r, `LIU_LOW_ZERO};
			else if (rd_enable)
				rdata_nxt = {1'b0, enable_r, `LIU_LOW_ZERO};
			irq_nxt = |(latch_r & enable_r);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			latch_r <= `LIU_LATCH_RESET;
			enable_r <= `LIU_ENABLE_RESET;
			reg_rdata_r <= `LIU_BYTE_RESET;
			irq_r <= 1'b0;
		end else begin
			latch_r <= latch_nxt;
			enable_r <= enable_nxt;
			reg_rdata_r <= rdata_nxt;
			irq_r <= irq_nxt;
		end
	end

	a_set_on_change: assert property (@(posedge clk) disable iff (reset)
		(|change) |=> ((latch_r & $past(change)) == $past(change)))
		else $error("change not latched");

	a_loop_both_edges: assert property (@(posedge clk) disable iff (reset)
		$changed(level_r[0]) |-> latch_r[0])
		else $error("loop-code transition not latched");

	a_read_clears: assert property (@(posedge clk) disable iff (reset)
		(ce && rd_latch && !(|change)) |=> (latch_r == `LIU_LATCH_RESET))
		else $error("read did not clear latches");

	a_read_data: assert property (@(posedge clk) disable iff (reset)
		(ce && rd_latch) |=> (reg_rdata_r[6:3] == $past(latch_r)))
		else $error("latch read data wrong");

	a_reserved_zero: assert property (@(posedge clk) disable iff (reset)
		reg_rdata_r[`LIU_BIT_RSVD] == 1'b0)
		else $error("reserved bit not zero");

	a_cv_no_wc: assert property (@(posedge clk) disable iff (reset)
		(ce && wr_latch && !reg_rd && !change[1]) |=> (latch_r[1] == $past(latch_r[1])))
		else $error("write cleared code violation latch");

	a_status_level: assert property (@(posedge clk) disable iff (reset)
		(ce && rd_status) |=> (reg_rdata_r[6:3] == $past(level_r)))
		else $error("status read not live level");

	a_irq_follows: assert property (@(posedge clk) disable iff (reset)
		ce |=> (irq_r == (|($past(latch_r) & $past(enable_r)))))
		else $error("irq not following enabled latches");

	a_hold_ce: assert property (@(posedge clk) disable iff (reset)
		!ce |=> ($stable(latch_r) && $stable(irq_r)))
		else $error("state moved with ce low");

	// reset, register-port, latch and interrupt checks
	a_reset_values: assert property (@(posedge clk)
		reset |=> (latch_r == `LIU_LATCH_RESET && enable_r == `LIU_ENABLE_RESET
			&& reg_rdata_r == `LIU_BYTE_RESET && !irq_r))
		else $error("state not cleared by reset");

	a_wc_clears: assert property (@(posedge clk) disable iff (reset)
		(ce && wr_latch && !reg_rd && !(|change))
			|=> ((latch_r & $past(reg_wdata[`LIU_FIELD_HI:`LIU_FIELD_LO]) & `LIU_WC_MASK)
			== `LIU_LATCH_RESET))
		else $error("write one did not clear latch");

	a_latch_holds: assert property (@(posedge clk) disable iff (reset)
		(ce && !rd_latch && !wr_latch) |=> ((latch_r & $past(latch_r)) == $past(latch_r)))
		else $error("latch dropped without access");

	a_no_false_set: assert property (@(posedge clk) disable iff (reset)
		!(|change) |=> ((latch_r & ~$past(latch_r)) == `LIU_LATCH_RESET))
		else $error("latch set without change");

	a_cv_read_clears: assert property (@(posedge clk) disable iff (reset)
		(ce && rd_latch && !change[1]) |=> !latch_r[1])
		else $error("code violation latch kept after read");

	a_low_bits_zero: assert property (@(posedge clk) disable iff (reset)
		reg_rdata_r[2:0] == `LIU_LOW_ZERO)
		else $error("unused low bits not zero");

	a_rdata_idle: assert property (@(posedge clk) disable iff (reset)
		(ce && !reg_rd) |=> (reg_rdata_r == `LIU_BYTE_RESET))
		else $error("read data not zero without read");

	a_unmapped_read: assert property (@(posedge clk) disable iff (reset)
		(ce && reg_rd && !rd_latch && !rd_status && !rd_enable)
			|=> (reg_rdata_r == `LIU_BYTE_RESET))
		else $error("unmapped read not zero");

	a_enable_read: assert property (@(posedge clk) disable iff (reset)
		(ce && rd_enable) |=> (reg_rdata_r == {1'b0, $past(enable_r), `LIU_LOW_ZERO}))
		else $error("enable read data wrong");

	a_enable_write: assert property (@(posedge clk) disable iff (reset)
		(ce && wr_enable) |=> (enable_r == $past(reg_wdata[`LIU_FIELD_HI:`LIU_FIELD_LO])))
		else $error("enable write not taken");

	a_enable_hold: assert property (@(posedge clk) disable iff (reset)
		(ce && !wr_enable) |=> $stable(enable_r))
		else $error("enable moved without write");

	a_freeze_ce: assert property (@(posedge clk) disable iff (reset)
		!ce |=> ($stable(reg_rdata_r) && $stable(enable_r) && $stable(level_r)))
		else $error("port state moved with ce low");

	a_irq_drops: assert property (@(posedge clk) disable iff (reset)
		(ce && !(|(latch_r & enable_r))) |=> !irq_r)
		else $error("irq high with no enabled latch");

	a_loop_irq: assert property (@(posedge clk) disable iff (reset)
		(change[0] && enable_r[0] && !wr_enable) ##1 ce |=> irq_r)
		else $error("enabled loop-code change gave no interrupt");

	// per-lane checks
	genvar k;
	generate
		for (k = 0; k < `LIU_COND_W; k++) begin : g_lane_chk
			a_lane_set: assert property (@(posedge clk) disable iff (reset)
				change[k] |=> latch_r[k])
				else $error("lane change not latched");

			a_lane_read: assert property (@(posedge clk) disable iff (reset)
				(ce && rd_latch) |=> (reg_rdata_r[`LIU_FIELD_LO + k] == $past(latch_r[k])))
				else $error("lane latch bit wrong");

			a_lane_status: assert property (@(posedge clk) disable iff (reset)
				(ce && rd_status) |=> (reg_rdata_r[`LIU_FIELD_LO + k] == $past(level_r[k])))
				else $error("lane status bit wrong");
		end
	endgenerate
endmodule
`default_nettype wire

// ### testbench/liu_channel_irq_status_latch_tb.sv
// self-checking bench for the channel change latch block
`timescale 1ns/100ps
`default_nettype none
`include "liu_consts.svh"
module liu_channel_irq_status_latch_tb;
import liu_types_pkg::*;
logic clk, reset, ce, reg_rd, reg_wr, irq_r;
logic [3:0] lv;
addr_type reg_addr;
byte_type reg_wdata, reg_rdata_r;
int n_mismatch, check_count;
liu_channel_irq_status_latch dut_u (.clk(clk), .reset(reset), .ce(ce),
	.drive_monitor_level(lv[3]), .fifo_limit_level(lv[2]),
	.code_violation_level(lv[1]), .loop_code_detect_level(lv[0]),
	.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
	.reg_rdata_r(reg_rdata_r), .irq_r(irq_r));
initial begin
	clk = 1'b0;
	forever #2.5 clk = ~clk;
end
task automatic cyc(input int n);
	repeat (n) @(posedge clk);
	#1;
endtask
task automatic chk(input string what, input byte_type exp, input byte_type got);
	check_count++;
	if (got !== exp) begin
		n_mismatch++;
		$display("FAIL %s expected %h seen %h", what, exp, got);
	end
endtask
// one read strobe, data checked in the cycle it stands
task automatic rd(input addr_type a, input byte_type exp);
	reg_addr = a;
	reg_rd = 1'b1;
	cyc(1);
	chk("read data", exp, reg_rdata_r);
	reg_rd = 1'b0;
	cyc(1);
endtask
task automatic wr(input addr_type a, input byte_type d);
	reg_addr = a;
	reg_wdata = d;
	reg_wr = 1'b1;
	cyc(1);
	reg_wr = 1'b0;
	cyc(1);
endtask
task automatic complete_run();
	$display("comparisons %0d mismatches %0d", check_count, n_mismatch);
	if (n_mismatch == 0 && check_count > 0) begin
		$display("NO MISMATCHES");
	end else begin
		$display("MISMATCHES SEEN");
	end
	$finish;
endtask
initial begin
	#20000;
	n_mismatch++;
	complete_run();
end
initial begin
	reset = 1'b1;
	ce = 1'b1;
	reg_rd = 1'b0;
	reg_wr = 1'b0;
	reg_addr = 12'h000;
	reg_wdata = 8'h00;
	lv = 4'h0;
	cyc(16);
	reset = 1'b0;
	rd(`LIU_OFS_LATCH, 8'h00);
	rd(`LIU_OFS_STATUS, 8'h00);
	rd(`LIU_OFS_ENABLE, 8'h00);
	$display("test reset values done");
	// one condition at a time, latch clears after its read
	for (int i = 0; i < 4; i++) begin
		lv[3 - i] = 1'b1;
		cyc(6);
		rd(`LIU_OFS_STATUS, {1'b0, lv, 3'h0});
		rd(`LIU_OFS_LATCH, 8'h40 >> i);
		rd(`LIU_OFS_LATCH, 8'h00);
	end
	$display("test set and read clear done");
	// falling edges on all four, then write one to clear
	lv = 4'h0;
	cyc(6);
	wr(`LIU_OFS_LATCH, 8'hff);
	rd(`LIU_OFS_LATCH, 8'h10);
	rd(`LIU_OFS_LATCH, 8'h00);
	$display("test write clear done");
	wr(`LIU_OFS_ENABLE, 8'hff);
	rd(`LIU_OFS_ENABLE, 8'h78);
	rd(12'h000, 8'h00);
	wr(`LIU_OFS_ENABLE, 8'h08);
	lv[0] = 1'b1;
	cyc(6);
	chk("irq rise", 8'h01, {7'h00, irq_r});
	rd(`LIU_OFS_LATCH, 8'h08);
	cyc(2);
	chk("irq clear", 8'h00, {7'h00, irq_r});
	lv[0] = 1'b0;
	cyc(6);
	chk("irq fall edge", 8'h01, {7'h00, irq_r});
	rd(`LIU_OFS_LATCH, 8'h08);
	// masked condition leaves the line low
	lv[3] = 1'b1;
	cyc(6);
	chk("irq masked", 8'h00, {7'h00, irq_r});
	rd(`LIU_OFS_LATCH, 8'h40);
	$display("test interrupt done");
	// frozen with ce low: no sampling, reads ignored
	ce = 1'b0;
	lv[3] = 1'b0;
	cyc(6);
	rd(`LIU_OFS_STATUS, 8'h00);
	ce = 1'b1;
	rd(`LIU_OFS_LATCH, 8'h00);
	cyc(6);
	rd(`LIU_OFS_LATCH, 8'h40);
	$display("test clock enable done");
	complete_run();
end
endmodule
`default_nettype wire
